// file: sgcr_pkg.sv
// shared constants and carrier types for the global config register bank
package sgcr_pkg;
   localparam int NPORT = 3;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 8;
   localparam int THR_W = 11;
   localparam int WIN_W = 26;

   localparam logic [ADDR_W-1:0] OFS_STORM_UPPER = 8'h06;
   localparam logic [ADDR_W-1:0] OFS_STORM_LOWER = 8'h07;
   localparam logic [ADDR_W-1:0] OFS_FACT_A = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_FACT_B = 8'h09;
   localparam logic [ADDR_W-1:0] OFS_FACT_C = 8'h0a;
   localparam logic [ADDR_W-1:0] OFS_HOST_CLK = 8'h0b;
   localparam logic [ADDR_W-1:0] OFS_PRIO_LOW = 8'h0c;

   localparam int STORM_UPPER_LSB = 0;
   localparam int STORM_UPPER_W = 3;
   localparam logic [2:0] RST_STORM_UPPER = 3'h0;
   localparam logic [7:0] RST_STORM_LOWER = 8'h63;
   localparam logic [7:0] RST_FACT_A = 8'h00;
   localparam logic [7:0] RST_FACT_B = 8'h24;
   localparam logic [7:0] RST_FACT_C = 8'h35;

   localparam int HCLK_SEL_LSB = 6;
   localparam logic [1:0] RST_HCLK_SEL = 2'h2;
   // reserved low bits of the host clock register read 00,10,0,0
   localparam logic [5:0] HCLK_RSVD_VAL = 6'h08;

   localparam int PRIO_T3_LSB = 6;
   localparam int PRIO_T2_LSB = 4;
   localparam int PRIO_T1_LSB = 2;
   localparam int PRIO_T0_LSB = 0;
   localparam logic [7:0] RST_PRIO_LOW = 8'h50;

   localparam int BLOCK_BYTES = 64;
   localparam int CLK_KHZ = 125000;
   localparam int WIN_FAST_MS = 67;
   localparam int WIN_SLOW_MS = 500;
   localparam int WIN_FAST_CYC = WIN_FAST_MS * CLK_KHZ;
   localparam int WIN_SLOW_CYC = WIN_SLOW_MS * CLK_KHZ;

   typedef enum logic [1:0] {
      HCLK_31M25,
      HCLK_62M5,
      HCLK_125M,
      HCLK_UNDEF
   } sgcr_hclk_e;

   typedef struct packed {
      logic blk;
      logic bcast;
      logic slow_rate;
   } sgcr_port_evt_s;

   typedef struct packed {
      logic valid;
      logic [2:0] tag;
   } sgcr_tag_s;

   typedef struct packed {
      logic valid;
      logic hit;
      logic [1:0] prio;
   } sgcr_prio_s;
endpackage : sgcr_pkg

// file: sgcr_storm_meter.sv
// per-port broadcast storm meter: window timer and block counter
`timescale 1ns/1ps
module sgcr_storm_meter
   import sgcr_pkg::*;
#(
   parameter int unsigned WIN_FAST = WIN_FAST_CYC,
   parameter int unsigned WIN_SLOW = WIN_SLOW_CYC
) (
   input wire logic clk_in,
   input wire logic srst_in,
   input wire sgcr_port_evt_s evt_in,
   input wire logic [THR_W-1:0] thr_in,
   output logic drop_out,
   output logic over_out
);
   logic [WIN_W-1:0] win_r;
   logic [WIN_W-1:0] win_nxt;
   logic [THR_W-1:0] cnt_r;
   logic [THR_W-1:0] cnt_nxt;
   logic drop_r;
   wire win_end = (win_r == '0);
   wire over = (cnt_r >= thr_in);
   wire bc_blk = evt_in.blk & evt_in.bcast;
   wire [WIN_W-1:0] reload = evt_in.slow_rate ?
      WIN_W'(WIN_SLOW - 1) : WIN_W'(WIN_FAST - 1);

   assign win_nxt = win_end ? reload : win_r - 1'b1;
   // window start clears the count, else each bcast block counts until it saturates at all ones
   assign cnt_nxt = win_end ? '0 :
      (bc_blk && cnt_r != '1) ? cnt_r + 1'b1 : cnt_r;

   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         win_r <= '0;
         cnt_r <= '0;
         drop_r <= 1'b0;
      end else begin
         win_r <= win_nxt;
         cnt_r <= cnt_nxt;
         drop_r <= bc_blk & over & ~win_end;
      end
   end

   assign drop_out = drop_r;
   assign over_out = over & ~win_end;
endmodule : sgcr_storm_meter

// file: sgcr_top.sv
// global config register bank: storm threshold, host clock, 802.1p remap
`timescale 1ns/1ps
module sgcr_top
   import sgcr_pkg::*;
#(
   parameter int unsigned WIN_FAST = WIN_FAST_CYC,
   parameter int unsigned WIN_SLOW = WIN_SLOW_CYC
) (
   input wire logic MCLK_IN,
   input wire logic SRST_IN,
   input wire logic [ADDR_W-1:0] REG_ADDR_IN,
   input wire logic REG_WR_IN,
   input wire logic [DATA_W-1:0] REG_WDATA_IN,
   input wire logic REG_RD_IN,
   output logic [DATA_W-1:0] REG_RDATA_OUT,
   output logic REG_RVALID_OUT,
   input wire sgcr_pkg::sgcr_port_evt_s [NPORT-1:0] PORT_EVT_IN,
   output logic [NPORT-1:0] STORM_DROP_OUT,
   output logic [NPORT-1:0] STORM_OVER_OUT,
   output logic [THR_W-1:0] STORM_THR_OUT,
   output sgcr_pkg::sgcr_hclk_e HOST_CLK_SEL_OUT,
   output logic [2:0] HOST_CLK_DIV_OUT,
   input wire sgcr_pkg::sgcr_tag_s TAG_IN,
   output sgcr_pkg::sgcr_prio_s PRIO_OUT
);
   import sgcr_pkg::*;

   function automatic logic hit(input logic [ADDR_W-1:0] a,
                                input logic [ADDR_W-1:0] o);
      hit = (a == o);
   endfunction : hit

   logic [STORM_UPPER_W-1:0] storm_upper_r;
   logic [7:0] storm_lower_r;
   logic [1:0] hclk_sel_r;
   logic [7:0] prio_low_r;
   logic [DATA_W-1:0] rdata_r;
   logic rvalid_r;
   sgcr_prio_s prio_r;
   sgcr_prio_s prio_nxt;
   logic [DATA_W-1:0] rdata_nxt;

   wire wr_upper = REG_WR_IN & hit(REG_ADDR_IN, OFS_STORM_UPPER);
   wire wr_lower = REG_WR_IN & hit(REG_ADDR_IN, OFS_STORM_LOWER);
   wire wr_hclk = REG_WR_IN & hit(REG_ADDR_IN, OFS_HOST_CLK);
   wire wr_prio = REG_WR_IN & hit(REG_ADDR_IN, OFS_PRIO_LOW);

   // factory-test registers are constants; writes have no path
   wire [DATA_W-1:0] rd_upper = {5'h00, storm_upper_r};
   wire [DATA_W-1:0] rd_hclk = {hclk_sel_r, HCLK_RSVD_VAL};

   assign rdata_nxt =
      hit(REG_ADDR_IN, OFS_STORM_UPPER) ? rd_upper :
      hit(REG_ADDR_IN, OFS_STORM_LOWER) ? storm_lower_r :
      hit(REG_ADDR_IN, OFS_FACT_A) ? RST_FACT_A :
      hit(REG_ADDR_IN, OFS_FACT_B) ? RST_FACT_B :
      hit(REG_ADDR_IN, OFS_FACT_C) ? RST_FACT_C :
      hit(REG_ADDR_IN, OFS_HOST_CLK) ? rd_hclk :
      hit(REG_ADDR_IN, OFS_PRIO_LOW) ? prio_low_r : 8'h00;

   always_ff @(posedge MCLK_IN) begin
      if (SRST_IN) begin
         storm_upper_r <= RST_STORM_UPPER;
         storm_lower_r <= RST_STORM_LOWER;
         hclk_sel_r <= RST_HCLK_SEL;
         prio_low_r <= RST_PRIO_LOW;
      end else begin
         if (wr_upper) begin
            storm_upper_r <= REG_WDATA_IN[STORM_UPPER_LSB +: STORM_UPPER_W];
         end
         if (wr_lower) begin
            storm_lower_r <= REG_WDATA_IN;
         end
         if (wr_hclk) begin
            hclk_sel_r <= REG_WDATA_IN[HCLK_SEL_LSB +: 2];
         end
         if (wr_prio) begin
            prio_low_r <= REG_WDATA_IN;
         end
      end
   end

   always_ff @(posedge MCLK_IN) begin
      if (SRST_IN) begin
         rdata_r <= '0;
         rvalid_r <= 1'b0;
      end else begin
         rvalid_r <= REG_RD_IN;
         if (REG_RD_IN) begin
            rdata_r <= rdata_nxt;
         end
      end
   end

   assign REG_RDATA_OUT = rdata_r;
   assign REG_RVALID_OUT = rvalid_r;

   // 11-bit threshold, upper bits from 0x06
   wire [THR_W-1:0] storm_thr = {storm_upper_r, storm_lower_r};
   assign STORM_THR_OUT = storm_thr;

   genvar gp;
   generate
      for (gp = 0; gp < NPORT; gp++) begin : g_port
         sgcr_storm_meter #(
            .WIN_FAST(WIN_FAST),
            .WIN_SLOW(WIN_SLOW)
         ) u_meter (
            .clk_in(MCLK_IN),
            .srst_in(SRST_IN),
            .evt_in(PORT_EVT_IN[gp]),
            .thr_in(storm_thr),
            .drop_out(STORM_DROP_OUT[gp]),
            .over_out(STORM_OVER_OUT[gp])
         );
      end
   endgenerate

   // host clock select and divide from the 125 MHz core clock
   assign HOST_CLK_SEL_OUT = sgcr_hclk_e'(hclk_sel_r);
   assign HOST_CLK_DIV_OUT =
      (hclk_sel_r == 2'h0) ? 3'h4 :
      (hclk_sel_r == 2'h1) ? 3'h2 : 3'h1;

   // 802.1p remap for tags 0..3; tags 4..7 report no hit
   always_comb begin
      prio_nxt = '0;
      prio_nxt.valid = TAG_IN.valid;
      case (TAG_IN.tag)
         3'h3: begin
            prio_nxt.hit = 1'b1;
            prio_nxt.prio = prio_low_r[PRIO_T3_LSB +: 2];
         end
         3'h2: begin
            prio_nxt.hit = 1'b1;
            prio_nxt.prio = prio_low_r[PRIO_T2_LSB +: 2];
         end
         3'h1: begin
            prio_nxt.hit = 1'b1;
            prio_nxt.prio = prio_low_r[PRIO_T1_LSB +: 2];
         end
         3'h0: begin
            prio_nxt.hit = 1'b1;
            prio_nxt.prio = prio_low_r[PRIO_T0_LSB +: 2];
         end
         default: begin
            prio_nxt.hit = 1'b0;
            prio_nxt.prio = 2'h0;
         end
      endcase
   end

   always_ff @(posedge MCLK_IN) begin
      if (SRST_IN) begin
         prio_r <= '0;
      end else begin
         prio_r <= prio_nxt;
      end
   end

   assign PRIO_OUT = prio_r;
endmodule : sgcr_top

// file: sgcr_top_assertions.sv
// port checks for the global config register bank
`timescale 1ns/1ps
module sgcr_chk
   import sgcr_pkg::*;
#(
   parameter int unsigned WIN_FAST = WIN_FAST_CYC,
   parameter int unsigned WIN_SLOW = WIN_SLOW_CYC
) (
   input wire logic MCLK_IN,
   input wire logic SRST_IN,
   input wire logic [ADDR_W-1:0] REG_ADDR_IN,
   input wire logic REG_WR_IN,
   input wire logic [DATA_W-1:0] REG_WDATA_IN,
   input wire logic REG_RD_IN,
   input wire logic [DATA_W-1:0] REG_RDATA_OUT,
   input wire logic REG_RVALID_OUT,
   input wire sgcr_port_evt_s [NPORT-1:0] PORT_EVT_IN,
   input wire logic [NPORT-1:0] STORM_DROP_OUT,
   input wire logic [NPORT-1:0] STORM_OVER_OUT,
   input wire logic [THR_W-1:0] STORM_THR_OUT,
   input wire sgcr_hclk_e HOST_CLK_SEL_OUT,
   input wire sgcr_tag_s TAG_IN,
   input wire sgcr_prio_s PRIO_OUT
);
   default clocking cb @(posedge MCLK_IN);
   endclocking
   default disable iff (SRST_IN);
   sequence s_wr(a);
      REG_WR_IN && REG_ADDR_IN == a;
   endsequence
   sequence s_rd(a);
      REG_RD_IN && REG_ADDR_IN == a;
   endsequence
   a_rvalid_after_rd: assert property (REG_RD_IN |=> REG_RVALID_OUT)
      else $error("read valid missing");
   a_thr_lower: assert property (s_wr(OFS_STORM_LOWER) |=>
      STORM_THR_OUT[7:0] == $past(REG_WDATA_IN)) else $error("thr low");
   a_thr_upper: assert property (s_wr(OFS_STORM_UPPER) |=>
      STORM_THR_OUT[10:8] == $past(REG_WDATA_IN[2:0]))
      else $error("thr high");
   a_reset_vals: assert property ($past(SRST_IN) |->
      STORM_THR_OUT == 11'h063 && HOST_CLK_SEL_OUT == HCLK_125M)
      else $error("reset values");
   a_clk_sel_wr: assert property (s_wr(OFS_HOST_CLK) |=>
      HOST_CLK_SEL_OUT == $past(REG_WDATA_IN[7:6])) else $error("clk sel");
   a_fact_read: assert property (s_rd(OFS_FACT_C) |=>
      REG_RDATA_OUT == 8'h35) else $error("factory c");
   a_prio_hit: assert property (TAG_IN.valid && !TAG_IN.tag[2] |=>
      PRIO_OUT.valid && PRIO_OUT.hit) else $error("remap hit");
   a_drop_cause: assert property (STORM_DROP_OUT[1] |->
      $past(STORM_OVER_OUT[1]) && $past(PORT_EVT_IN[1].bcast))
      else $error("drop cause");
endmodule : sgcr_chk
bind sgcr_top sgcr_chk #(.WIN_FAST(WIN_FAST), .WIN_SLOW(WIN_SLOW))
   sgcr_chk_inst (.MCLK_IN, .SRST_IN, .REG_ADDR_IN, .REG_WR_IN,
   .REG_WDATA_IN, .REG_RD_IN, .REG_RDATA_OUT, .REG_RVALID_OUT,
   .PORT_EVT_IN, .STORM_DROP_OUT, .STORM_OVER_OUT, .STORM_THR_OUT,
   .HOST_CLK_SEL_OUT, .TAG_IN, .PRIO_OUT);

// file: tb_top.sv
// testbench for the global config register bank
`timescale 1ns/1ps
module tb_top;
   import sgcr_pkg::*;
   logic MCLK_IN = 0, SRST_IN = 1, REG_WR_IN = 0, REG_RD_IN = 0;
   logic [7:0] REG_ADDR_IN = '0, REG_WDATA_IN = '0, REG_RDATA_OUT;
   logic REG_RVALID_OUT;
   sgcr_port_evt_s [NPORT-1:0] PORT_EVT_IN = '0;
   logic [NPORT-1:0] STORM_DROP_OUT, STORM_OVER_OUT;
   logic [THR_W-1:0] STORM_THR_OUT;
   sgcr_hclk_e HOST_CLK_SEL_OUT;
   logic [2:0] HOST_CLK_DIV_OUT;
   sgcr_tag_s TAG_IN = '0;
   sgcr_prio_s PRIO_OUT;
   int n_errors = 0, check_count = 0;
   // address, write data, expected read back
   logic [23:0] rows [9] = '{24'h07_10_10, 24'h06_ff_07, 24'h08_ff_00,
      24'h09_00_24, 24'h0a_00_35, 24'h0b_3f_08, 24'h0b_40_48,
      24'h0c_e4_e4, 24'h20_55_00};
   sgcr_top #(.WIN_FAST(20), .WIN_SLOW(40)) sgcr_top_inst (.MCLK_IN,
      .SRST_IN, .REG_ADDR_IN, .REG_WR_IN, .REG_WDATA_IN, .REG_RD_IN,
      .REG_RDATA_OUT, .REG_RVALID_OUT, .PORT_EVT_IN, .STORM_DROP_OUT,
      .STORM_OVER_OUT, .STORM_THR_OUT, .HOST_CLK_SEL_OUT,
      .HOST_CLK_DIV_OUT, .TAG_IN, .PRIO_OUT);
   initial begin
      forever #4 MCLK_IN = ~MCLK_IN;
   end
   task automatic cyc;
      @(posedge MCLK_IN);
      #1;
   endtask : cyc
   task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
      check_count++;
      if (g !== e) begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic wr(logic [7:0] a, logic [7:0] d);
      REG_ADDR_IN = a;
      REG_WDATA_IN = d;
      REG_WR_IN = 1'b1;
      cyc();
      REG_WR_IN = 1'b0;
      cyc();
   endtask : wr
   task automatic rd(logic [7:0] a, logic [7:0] e);
      REG_ADDR_IN = a;
      REG_RD_IN = 1'b1;
      cyc();
      REG_RD_IN = 1'b0;
      chk("rdata", 16'(e), 16'(REG_RDATA_OUT));
      chk("rvalid", 16'h1, 16'(REG_RVALID_OUT));
      cyc();
      chk("rvalid_end", 16'h0, 16'(REG_RVALID_OUT));
   endtask : rd
   task automatic blk(int p, logic e);
      PORT_EVT_IN[p] = 3'h6;
      cyc();
      chk("drop", 16'(e), 16'(STORM_DROP_OUT[p]));
   endtask : blk
   task automatic give_verdict;
      $display("checks %0d errors %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : give_verdict
   initial begin
      #60000;
      n_errors++;
      give_verdict();
   end
   initial begin
      logic [7:0] rv [7] = '{8'h00, 8'h63, 8'h00, 8'h24, 8'h35, 8'h88,
         8'h50};
      logic [2:0] dv [4] = '{3'h4, 3'h2, 3'h1, 3'h1};
      repeat (8) cyc();
      SRST_IN = 1'b0;
      for (int i = 0; i < 7; i++) rd(8'(6 + i), rv[i]);
      chk("thr", 16'h063, 16'(STORM_THR_OUT));
      for (int i = 0; i < 9; i++) begin
         wr(rows[i][23:16], rows[i][15:8]);
         rd(rows[i][23:16], rows[i][7:0]);
      end
      chk("thr", 16'h710, 16'(STORM_THR_OUT));
      for (int i = 0; i < 6; i++) begin
         TAG_IN = {1'b1, 3'(i)};
         cyc();
         chk("prio", 16'(i < 4 ? 4'hc + 4'(i) : 4'h8), 16'(PRIO_OUT));
      end
      TAG_IN = '0;
      for (int i = 0; i < 4; i++) begin
         wr(8'h0b, 8'(i << 6));
         chk("sel", 16'(i), 16'(HOST_CLK_SEL_OUT));
         chk("div", 16'(dv[i]), 16'(HOST_CLK_DIV_OUT));
      end
      // software settles on the slowest host clock
      wr(8'h0b, 8'h00);
      chk("sel_slow", 16'h0, 16'(HOST_CLK_SEL_OUT));
      SRST_IN = 1'b1;
      repeat (8) cyc();
      SRST_IN = 1'b0;
      chk("sel_rst", 16'h2, 16'(HOST_CLK_SEL_OUT));
      chk("thr_rst", 16'h063, 16'(STORM_THR_OUT));
      wr(8'h07, 8'h02);
      for (int i = 0; i < 3; i++) blk(1, i == 2);
      PORT_EVT_IN = '0;
      chk("over", 16'h1, 16'(STORM_OVER_OUT[1]));
      repeat (25) cyc();
      blk(1, 1'b0);
      PORT_EVT_IN = '0;
      chk("over_new", 16'h0, 16'(STORM_OVER_OUT[1]));
      wr(8'h07, 8'h00);
      blk(0, 1'b1);
      PORT_EVT_IN = '0;
      chk("over_zero", 16'h7, 16'(STORM_OVER_OUT));
      give_verdict();
   end
endmodule : tb_top
